// ==== hw/bit_clock_divider.v ====
// Purpose: Counts one serial bit period and marks its leading and trailing half.
// Assumes: ratio is at least two and stays steady while run is high.
// Notes: Counter restarts at zero whenever run drops, so the first lead comes at once.
`default_nettype none

module bit_clock_divider #(
  parameter W = 10
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [W-1:0] ratio,
  output wire lead_pulse,
  output wire trail_pulse
);

  reg [W-1:0] cnt_q;
  wire [W-1:0] half = ratio >> 1;
  wire [W-1:0] last = ratio - {{(W-1){1'b0}}, 1'b1};

  assign lead_pulse = run & (cnt_q == {W{1'b0}});
  assign trail_pulse = run & (cnt_q == half);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= {W{1'b0}};
    else if (!run || cnt_q >= last)
      cnt_q <= {W{1'b0}};
    else
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
  end

endmodule

`default_nettype wire

// ==== hw/spi_cfg_map.vh ====
// Purpose: Register offsets, field positions, reset values and divider codes of the serial port.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only; included by the serial port top module.
//
// Overview of operation
// - Secondary divider: code 111 is 1, 000 is 8.
// - Primary divider: 11,10,01,00 give 1,4,16,64.
// - Serial clock is input clock over product; a product of 1 is raised to 2.
// - Clock edge select ignored when framed mode on.
// - Control two bit 15 enables framed operation.
// - Bit 14: frame sync input in slave, else output in master.
// - Bit 13: frame sync active high, else low.
// - Bit 1: pulse with first bit, else before.
// - Bit 0: multi-entry buffer, else single entry.
// - Clock polarity bit sets serial clock idle level.
// - Slave select use gates shifting in unframed slave; it does not release the data pin.
`ifndef SPI_CFG_MAP_VH
`define SPI_CFG_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CON1 8'h00
`define OFS_CON2 8'h04
`define OFS_DATA 8'h08
`define OFS_STAT 8'h0C

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define CON1_RESET 16'h0000
`define CON2_RESET 16'h0000
`define CON1_MASK 16'h19FF
`define CON2_MASK 16'hE003

// ----------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------
`define CON1_PRI_LO 0
`define CON1_PRI_HI 1
`define CON1_SEC_LO 2
`define CON1_SEC_HI 4
`define CON1_MASTER 5
`define CON1_CKP 6
`define CON1_SLAVE_SELECT_USE 7
`define CON1_CKE 8
`define CON1_OUT_OFF 11
`define CON1_CLK_OFF 12

// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define CON2_FRAMED 15
`define CON2_FDIR 14
`define CON2_FPOL 13
`define CON2_FEDGE 1
`define CON2_BUFEN 0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STAT_ON 0
`define STAT_BUSY 1
`define STAT_FULL 2
`define STAT_EMPTY 3
`define STAT_CNT_LO 4
`define STAT_PER_LO 8

// ----------------------------------------------------------------
// Divider ratios
// ----------------------------------------------------------------
`define PRI_CODE_1 2'h3
`define PRI_CODE_4 2'h2
`define PRI_CODE_16 2'h1
`define PRI_DIV_1 10'h001
`define PRI_DIV_4 10'h004
`define PRI_DIV_16 10'h010
`define PRI_DIV_64 10'h040
`define SEC_DIV_BASE 4'h8
`define MIN_RATIO 10'h002

`endif

// ==== hw/spi_clock_and_frame_config.v ====
// Purpose: Serial port clock prescaler and framed-mode control behind an APB slave.
// Assumes: DEPTH is a power of two; pclk is the instruction clock.
// Notes: Pins of the partner pass two flip-flops before use.
`include "spi_cfg_map.vh"
`default_nettype none

module spi_clock_and_frame_config #(
  parameter BITS = 8,
  parameter DEPTH = 4,
  parameter PW = 2,
  parameter CW = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_clock_in,
  input wire select_in,
  output reg serial_clock_out,
  output reg serial_clock_oe,
  output reg serial_out_pin,
  output reg serial_out_oe,
  output reg select_out,
  output reg select_oe
);

  // ----------------------------------------------------------------
  // Registers and decoded fields
  // ----------------------------------------------------------------
  reg [15:0] con1_q;
  reg [15:0] con2_q;
  reg on_q;

  wire [1:0] primary_divider_sel = con1_q[`CON1_PRI_HI:`CON1_PRI_LO];
  wire [2:0] secondary_divider_sel = con1_q[`CON1_SEC_HI:`CON1_SEC_LO];
  wire master_select = con1_q[`CON1_MASTER];
  wire clock_idle_polarity = con1_q[`CON1_CKP];
  wire slave_select_use = con1_q[`CON1_SLAVE_SELECT_USE];
  wire serial_out_pin_off = con1_q[`CON1_OUT_OFF];
  wire serial_clock_pin_off = con1_q[`CON1_CLK_OFF];
  wire framed_mode_on = con2_q[`CON2_FRAMED];
  wire frame_sync_direction = con2_q[`CON2_FDIR];
  wire frame_sync_polarity = con2_q[`CON2_FPOL];
  wire frame_sync_edge = con2_q[`CON2_FEDGE];
  wire multi_entry_buffer_on = con2_q[`CON2_BUFEN];

  wire cke_eff = con1_q[`CON1_CKE] & ~framed_mode_on;
  wire pre = framed_mode_on & ~frame_sync_edge;

  // ----------------------------------------------------------------
  // Prescaler ratio
  // ----------------------------------------------------------------
  reg [9:0] pri_ratio;
  always @*
  begin
    case (primary_divider_sel)
      `PRI_CODE_1: pri_ratio = `PRI_DIV_1;
      `PRI_CODE_4: pri_ratio = `PRI_DIV_4;
      `PRI_CODE_16: pri_ratio = `PRI_DIV_16;
      default: pri_ratio = `PRI_DIV_64;
    endcase
  end

  wire [3:0] sec_ratio = `SEC_DIV_BASE - {1'b0, secondary_divider_sel};
  wire [9:0] ratio_raw = pri_ratio * {6'h00, sec_ratio};
  // A one-to-one product cannot make a serial clock; it runs at half rate instead.
  wire [9:0] ratio = (ratio_raw < `MIN_RATIO) ? `MIN_RATIO : ratio_raw;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  reg [BITS-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wp_q;
  reg [PW-1:0] rp_q;
  reg [CW-1:0] cnt_q;

  wire [CW-1:0] cap = multi_entry_buffer_on ? DEPTH[CW-1:0] : {{(CW-1){1'b0}}, 1'b1};
  wire full = (cnt_q >= cap);
  wire empty = (cnt_q == {CW{1'b0}});
  wire [BITS-1:0] head = empty ? {BITS{1'b0}} : mem[rp_q];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready;
  wire wr = commit & pwrite;
  wire mapped = (paddr == `OFS_CON1) | (paddr == `OFS_CON2) | (paddr == `OFS_DATA) | (paddr == `OFS_STAT);
  wire push = wr & (paddr == `OFS_DATA) & ~full;

  reg busy_q;
  reg [5:0] per_q;
  reg [31:0] rd_word;
  always @*
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `OFS_CON1: rd_word = {16'h0000, con1_q};
      `OFS_CON2: rd_word = {16'h0000, con2_q};
      `OFS_STAT:
      begin
        rd_word[`STAT_ON] = on_q;
        rd_word[`STAT_BUSY] = busy_q;
        rd_word[`STAT_FULL] = full;
        rd_word[`STAT_EMPTY] = empty;
        rd_word[`STAT_CNT_LO +: CW] = cnt_q;
        rd_word[`STAT_PER_LO +: 6] = per_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      con1_q <= `CON1_RESET;
      con2_q <= `CON2_RESET;
      on_q <= 1'b0;
    end
    else
    begin
      if (setup)
      begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
      else if (commit)
        pready <= 1'b0;
      if (wr && paddr == `OFS_CON1)
        con1_q <= pwdata[15:0] & `CON1_MASK;
      if (wr && paddr == `OFS_CON2)
        con2_q <= pwdata[15:0] & `CON2_MASK;
      if (wr && paddr == `OFS_STAT)
        on_q <= pwdata[`STAT_ON];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and slave edge detection
  // ----------------------------------------------------------------
  reg sck_s1;
  reg sck_s2;
  reg sck_s3;
  reg sel_s1;
  reg sel_s2;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
    end
    else
    begin
      sck_s1 <= serial_clock_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sel_s1 <= select_in;
      sel_s2 <= sel_s1;
    end
  end

  // Leading edge goes from idle to active level; trailing edge returns to idle.
  wire s_rise = sck_s2 & ~sck_s3;
  wire s_fall = ~sck_s2 & sck_s3;
  wire s_lead = clock_idle_polarity ? s_fall : s_rise;
  wire s_trail = clock_idle_polarity ? s_rise : s_fall;

  reg fseen_q;
  wire fsync_act = (sel_s2 == frame_sync_polarity);
  wire gate_ok = framed_mode_on ? (~frame_sync_direction | fseen_q | fsync_act)
                                : (~slave_select_use | ~sel_s2);

  // ----------------------------------------------------------------
  // Bit clock divider, master mode only
  // ----------------------------------------------------------------
  wire div_lead;
  wire div_trail;
  wire run = busy_q & master_select & on_q;

  bit_clock_divider #(
    .W(10)
  ) u_div (
    .clk(pclk),
    .rst_n(presetn),
    .run(run),
    .ratio(ratio),
    .lead_pulse(div_lead),
    .trail_pulse(div_trail)
  );

  wire slave_on = on_q & ~master_select;
  wire lead_ev = master_select ? div_lead : (slave_on & gate_ok & s_lead);
  wire trail_ev = master_select ? div_trail : (slave_on & s_trail);
  wire start = on_q & ~busy_q & (master_select ? ~empty : lead_ev);

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  localparam [5:0] BITS6 = BITS[5:0];
  wire [5:0] total = BITS6 + {5'h00, pre};

  reg [BITS-1:0] sh_q;
  reg so_q;
  reg sck_q;
  reg fs_q;
  reg busy_d;
  reg [5:0] per_d;
  reg [BITS-1:0] sh_d;
  reg so_d;
  reg sck_d;
  reg fs_d;
  reg fseen_d;

  always @*
  begin
    busy_d = busy_q;
    per_d = per_q;
    sh_d = sh_q;
    so_d = so_q;
    sck_d = sck_q;
    fs_d = fs_q;
    fseen_d = fseen_q;
    if (slave_on && framed_mode_on && frame_sync_direction && fsync_act && !busy_q)
      fseen_d = 1'b1;
    if (start)
    begin
      busy_d = 1'b1;
      per_d = 6'h00;
      sh_d = head;
      if (cke_eff)
      begin
        so_d = head[BITS-1];
        sh_d = {head[BITS-2:0], 1'b0};
      end
    end
    if (lead_ev && busy_d)
    begin
      sck_d = ~clock_idle_polarity;
      fs_d = framed_mode_on & ~frame_sync_direction & (per_d == 6'h00);
      if (!cke_eff && per_d >= {5'h00, pre})
      begin
        so_d = sh_d[BITS-1];
        sh_d = {sh_d[BITS-2:0], 1'b0};
      end
      per_d = per_d + 6'h01;
    end
    if (trail_ev && busy_d)
    begin
      sck_d = clock_idle_polarity;
      if (per_d == total)
      begin
        busy_d = 1'b0;
        fseen_d = 1'b0;
      end
      else if (cke_eff && per_d > {5'h00, pre})
      begin
        so_d = sh_d[BITS-1];
        sh_d = {sh_d[BITS-2:0], 1'b0};
      end
    end
    // Losing the select line or the port mid-frame drops the frame.
    if (!on_q || (!master_select && !gate_ok))
    begin
      busy_d = 1'b0;
      fseen_d = 1'b0;
    end
    if (!busy_d)
    begin
      sck_d = clock_idle_polarity;
      fs_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      per_q <= 6'h00;
      sh_q <= {BITS{1'b0}};
      so_q <= 1'b0;
      sck_q <= 1'b0;
      fs_q <= 1'b0;
      fseen_q <= 1'b0;
      wp_q <= {PW{1'b0}};
      rp_q <= {PW{1'b0}};
      cnt_q <= {CW{1'b0}};
      serial_clock_out <= 1'b0;
      serial_clock_oe <= 1'b0;
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
      select_out <= 1'b1;
      select_oe <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      per_q <= per_d;
      sh_q <= sh_d;
      so_q <= so_d;
      sck_q <= sck_d;
      fs_q <= fs_d;
      fseen_q <= fseen_d;
      if (push)
      begin
        mem[wp_q] <= pwdata[BITS-1:0];
        wp_q <= wp_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (start && !empty)
        rp_q <= rp_q + {{(PW-1){1'b0}}, 1'b1};
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, start & ~empty};
      serial_clock_out <= sck_d;
      serial_clock_oe <= on_q & master_select & ~serial_clock_pin_off;
      serial_out_pin <= so_d;
      serial_out_oe <= on_q & ~serial_out_pin_off;
      select_out <= fs_d ? frame_sync_polarity : ~frame_sync_polarity;
      select_oe <= on_q & master_select & framed_mode_on & ~frame_sync_direction;
    end
  end

endmodule

`default_nettype wire

// ==== test/serial_partner.sv ====
// Purpose: Far-side serial partner: samples data on the trailing clock edge and clocks a slave port.
// Assumes: Serial clock idles low on both sides.
// Notes: Its own clock stands still outside a burst, as a real master's does.
`default_nettype none
module serial_partner (
  input wire logic pclk,
  input wire logic sck_dev,
  input wire logic sdo,
  input wire logic go,
  input wire logic sel_lvl,
  output logic sck_drv,
  output logic sel_n,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  logic sck_q = 1'b0;
  logic sel_q = 1'b1;
  logic [7:0] got_q = 8'h00;
  wire logic sck = sck_dev | sck_q;
  assign sck_drv = sck_q;
  assign sel_n = sel_q;
  assign got = got_q;
  // A burst is eight clock pulses of sixteen pclk cycles each.
  always @(posedge pclk)
  begin
    sel_q <= sel_lvl;
    if (!go)
    begin
      cnt <= 8'h00;
      sck_q <= 1'b0;
    end
    else if (cnt != 8'h80)
    begin
      cnt <= cnt + 8'h01;
      if (cnt[2:0] == 3'h7)
        sck_q <= ~sck_q;
    end
  end
  always @(negedge sck)
    got_q <= {got_q[6:0], sdo};
endmodule
`default_nettype wire

// ==== test/spi_cfg_chk.sv ====
// Purpose: Port checks of the serial port setup block.
// Assumes: One clock, pclk; presetn is asynchronous.
// Notes: Shadow words follow completed APB writes, so readback and enables can be judged.
`default_nettype none
module spi_cfg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clock_in,
  input wire logic select_in,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic select_out,
  input wire logic select_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic on_q;
  wire logic wr = psel && penable && pready && pwrite;
  wire logic rd = psel && penable && pready && !pwrite;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
      on_q <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == 8'h00)
        c1_q <= pwdata[15:0] & 16'h19FF;
      if (paddr == 8'h04)
        c2_q <= pwdata[15:0] & 16'hE003;
      if (paddr == 8'h0C)
        on_q <= pwdata[0];
    end
  end
  con2_zero_a: assert property (rd && paddr == 8'h04 |-> prdata[31:16] == 16'h0000 && prdata[12:2] == 11'h000)
    else $error("control two reserved bits not zero");
  con2_hi_a: assert property (rd && paddr == 8'h04 |-> prdata[15:13] == c2_q[15:13])
    else $error("control two frame fields wrong");
  con2_lo_a: assert property (rd && paddr == 8'h04 |-> prdata[1:0] == c2_q[1:0])
    else $error("control two low fields wrong");
  con1_rd_a: assert property (rd && paddr == 8'h00 |-> prdata == {16'h0000, c1_q})
    else $error("control one readback wrong");
  sync_oe_a: assert property (select_oe == ($past(on_q) && $past(c1_q[5]) && $past(c2_q[15]) && !$past(c2_q[14])))
    else $error("frame sync enable wrong");
  clk_oe_a: assert property (serial_clock_oe == ($past(on_q) && $past(c1_q[5]) && !$past(c1_q[12])))
    else $error("serial clock driven outside master mode");
  clk_idle_a: assert property (!on_q && !$past(on_q) |-> serial_clock_out == $past(c1_q[6]))
    else $error("serial clock idle level wrong");
  sync_idle_a: assert property (!on_q && !$past(on_q) |-> select_out == !$past(c2_q[13]))
    else $error("frame sync idle level wrong");
endmodule
bind spi_clock_and_frame_config spi_cfg_chk chk (.*);
`default_nettype wire

// ==== test/spi_clock_and_frame_config_bench.sv ====
// Purpose: Self-checking bench for the serial port clock and frame setup.
// Assumes: Zero-wait APB slave on a 40 MHz pclk.
// Notes: Every wait is bounded; a wait that runs out counts as a mismatch.
`default_nettype none
module spi_clock_and_frame_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic sel_lvl = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rd;
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sck_in, sel_in, sck_o, sck_oe, sdo, sdo_oe, sel_o, sel_oe;
  wire logic [7:0] got;
  int bad_count = 0;
  int n_tests = 0;
  always #12.5 pclk = ~pclk;
  spi_clock_and_frame_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(sck_in), .select_in(sel_in), .serial_clock_out(sck_o), .serial_clock_oe(sck_oe),
    .serial_out_pin(sdo), .serial_out_oe(sdo_oe), .select_out(sel_o), .select_oe(sel_oe));
  serial_partner peer (.pclk(pclk), .sck_dev(sck_o), .sdo(sdo), .go(go), .sel_lvl(sel_lvl),
    .sck_drv(sck_in), .sel_n(sel_in), .got(got));
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h00000001, 32'h00000000);
    close_out();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 9; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 9)
      hang("apb wait");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for the serial clock (s=0) or frame sync (s=1) to reach v; n counts the cycles.
  task automatic lvl(input bit s, input logic v, output int n);
    for (n = 0; n < 3000; n++)
    begin
      if ((s ? sel_o : sck_o) === v)
        return;
      @(posedge pclk);
    end
    hang("pin wait");
  endtask
  // Counts serial clock pulses until the clock has rested for 40 cycles.
  task automatic pulses(output int n);
    int k;
    int idle;
    logic last;
    n = 0;
    idle = 0;
    last = 1'b0;
    for (k = 0; k < 3000 && idle < 40; k++)
    begin
      if (sck_o === 1'b1 && last !== 1'b1)
        n++;
      idle = (sck_o === 1'b1) ? 0 : idle + 1;
      last = sck_o;
      @(posedge pclk);
    end
    if (k == 3000)
      hang("pulse count");
  endtask
  task automatic run(input logic [15:0] c1, input logic [15:0] c2, input logic [7:0] b);
    apb(1'b1, 8'h00, {16'h0000, c1});
    apb(1'b1, 8'h04, {16'h0000, c2});
    apb(1'b1, 8'h08, {24'h000000, b});
    apb(1'b1, 8'h0C, 32'h00000001);
  endtask
  // Turning the port off mid-frame is avoided: wait for idle and empty first.
  task automatic drain();
    int k;
    for (k = 0; k < 300; k++)
    begin
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h00000000);
      if (rd[1] === 1'b0 && rd[3] === 1'b1)
        break;
    end
    if (k == 300)
      hang("frame end");
    apb(1'b1, 8'h0C, 32'h00000000);
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h04, 32'h00000000);
    chk("con2 reset", 32'h00000000, rd);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    apb(1'b0, 8'h04, 32'h00000000);
    chk("con2 mask", 32'h0000E003, rd);
    apb(1'b1, 8'h00, 32'h0000FFFF);
    apb(1'b0, 8'h00, 32'h00000000);
    chk("con1 mask", 32'h000019FF, rd);
    chk("clock idle", 32'h00000001, sck_o);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped err", 32'h00000001, err);
    apb(1'b1, 8'h04, 32'h00000000);
  endtask
  task automatic t_div();
    int i, p, s, r, a, b;
    for (i = 0; i < 13; i++)
    begin
      p = i < 8 ? 2 : (i < 12 ? i - 8 : 3);
      s = i < 8 ? i : (i < 12 ? 6 : 7);
      r = (1 << (2 * (3 - p))) * (8 - s);
      if (r < 2)
        r = 2;
      run({11'h001, s[2:0], p[1:0]}, 16'h0000, 8'hA5);
      lvl(1'b0, 1'b1, a);
      lvl(1'b0, 1'b0, a);
      lvl(1'b0, 1'b1, b);
      chk("bit period", r, a + b);
      drain();
    end
  endtask
  task automatic t_frame();
    int i, a;
    for (i = 0; i < 4; i++)
    begin
      run({7'h00, i[0], 8'h3A}, {2'h2, i[1], 11'h000, i[0], 1'b0}, 8'h5A);
      lvl(1'b1, i[1], a);
      chk("sync enable", 32'h00000001, sel_oe);
      chk("clock enable", 32'h00000001, sck_oe);
      // The preceding sync period carries a clock pulse of its own, so the frame has one pulse more.
      pulses(a);
      chk("sync lead", i[0] ? 8 : 9, a);
      drain();
      chk("framed byte", 32'h0000005A, got);
      chk("sync idle", !i[1], sel_o);
    end
  endtask
  task automatic t_buf();
    apb(1'b1, 8'h00, 32'h0000003A);
    apb(1'b1, 8'h08, 32'h00000011);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("legacy full", 32'h00000014, rd[6:0]);
    apb(1'b1, 8'h0C, 32'h00000001);
    drain();
    apb(1'b1, 8'h04, 32'h00000001);
    repeat (3) apb(1'b1, 8'h08, 32'h00000022);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("multi partial", 32'h00000030, rd[6:0]);
    apb(1'b1, 8'h08, 32'h00000022);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("multi full", 32'h00000044, rd[6:0]);
    apb(1'b1, 8'h0C, 32'h00000001);
    drain();
    apb(1'b1, 8'h04, 32'h00000000);
  endtask
  task automatic t_slave();
    run(16'h0080, 16'h0000, 8'hC3);
    go <= 1'b1;
    repeat (140) @(posedge pclk);
    go <= 1'b0;
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("gated count", 32'h00000001, rd[6:4]);
    chk("slave clock off", 32'h00000000, sck_oe);
    chk("slave data on", 32'h00000001, sdo_oe);
    sel_lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    go <= 1'b1;
    repeat (140) @(posedge pclk);
    go <= 1'b0;
    sel_lvl <= 1'b1;
    chk("slave byte", 32'h000000C3, got);
    apb(1'b1, 8'h0C, 32'h00000000);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_div();
    t_frame();
    t_buf();
    t_slave();
    close_out();
  end
endmodule
`default_nettype wire
